// ===== rtl/pll_pkg.sv
// Package: constants and types of the synthesizer digital core
// Behaviour
// - Input-select bit 1 routes the high-band oscillator input to the programmable divider.
// - High-band path has a divide-by-two prescaler; effective division is twice the setting.
// - Input-select bit 0 routes the low-band oscillator input to the programmable divider.
// - Low band with swallow mode 1 divides by the 16-bit setting exactly.
// - Low band with swallow mode 0 uses a 12-bit direct divider, setting 4 to 4095.
// - Reference comes from the 75 kHz crystal, eight selectable rates.
// - Serial clock from the controller times all input and output bits.
// - Outside read mode, serial data out pulls low on unlock only when the three-bit output-control field is 1 and enable is low.
// - Reset initialises all control state.
// - Phase comparator with dead zone, unlock detection and deadlock clear.
// - Phase output high when divided oscillator is fast, low when slow, else floats.
package pll_pkg;
    localparam int ADDR_BITS = 8;
    localparam int DATA_BITS = 24;
    localparam logic [5:0] ADDR_LAST = 6'h07;
    localparam logic [5:0] FRAME_LAST = 6'h1f;
    localparam logic [5:0] FRAME_BITS = 6'h20;
    localparam logic [7:0] ADDR_CTRL_A = 8'h28;
    localparam logic [7:0] ADDR_CTRL_B = 8'h29;
    localparam logic [7:0] ADDR_READ = 8'h2a;
    // Crystal to reference divisors (75 kHz input)
    localparam logic [6:0] REF_DIV_25K = 7'h03;
    localparam logic [6:0] REF_DIV_12K5 = 7'h06;
    localparam logic [6:0] REF_DIV_6K25 = 7'h0c;
    localparam logic [6:0] REF_DIV_3K125 = 7'h18;
    localparam logic [6:0] REF_DIV_5K = 7'h0f;
    localparam logic [6:0] REF_DIV_1K = 7'h4b;
    localparam logic [6:0] REF_DIV_3K = 7'h19;
    localparam logic [6:0] REF_DIV_15K = 7'h05;
    localparam logic [3:0] REF_SEL_INHIBIT_STOP = 4'he;
    localparam logic [3:0] REF_SEL_INHIBIT = 4'hf;
    localparam logic [2:0] OUTC_UNLOCK = 3'h1;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int DEADLOCK_NS = 10000;
    localparam logic [15:0] DEADLOCK_CYC = 16'(DEADLOCK_NS / CLK_PERIOD_NS);
    localparam logic [15:0] DEAD_ZONE_CYC = 16'h0002;
    localparam logic [15:0] UNLOCK_LIMIT_RST = 16'h0020;
    // Register map
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_WORD_A = 4'h4;
    localparam logic [3:0] OFS_WORD_B = 4'h8;
    localparam logic [3:0] OFS_UNLOCK_LIMIT = 4'hc;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] spare;
        logic [3:0] ref_sel;
        logic swallow_mode_bit;
        logic input_select_bit;
        logic [15:0] divisor;
    } ctrl_a_t;

    typedef struct packed {
        logic [19:0] spare;
        logic dead_zone;
        logic [2:0] out_ctrl;
    } ctrl_b_t;

    typedef struct packed {
        logic unlock;
        logic inhibit;
        logic phase_up;
        logic phase_dn;
    } status_t;
endpackage

// ===== rtl/pll_serial_port.sv
// Serial control port logic clocked by the controller's serial clock
`timescale 1ns/1ps
module pll_serial_port
    import pll_pkg::*;
(
    input wire logic i_serial_clock,
    input wire logic i_rst_b,
    input wire logic i_enable,
    input wire logic i_serial_data_in,
    input wire status_t i_status,
    output logic [DATA_BITS-1:0] o_word_a,
    output logic [DATA_BITS-1:0] o_word_b,
    output logic o_toggle_a,
    output logic o_toggle_b,
    output logic o_read_mode,
    output logic o_out_bit
);
    logic [5:0] bit_cnt_q;
    logic [31:0] shift_q;
    logic [ADDR_BITS-1:0] addr_q;
    logic [DATA_BITS-1:0] out_sh_q;
    status_t status_m_q;
    status_t status_s_q;

    // Frame state clears whenever enable is low
    wire frame_rst_b = i_rst_b & i_enable;
    wire [31:0] shift_next = {i_serial_data_in, shift_q[31:1]};
    wire addr_done = (bit_cnt_q == ADDR_LAST);
    wire word_done = (bit_cnt_q == FRAME_LAST);
    wire [ADDR_BITS-1:0] addr_now = shift_next[31:24];
    assign o_out_bit = out_sh_q[0];

    // ----------------------------------------
    // Bit shifter, address and read-out
    // ----------------------------------------
    always_ff @(posedge i_serial_clock or negedge frame_rst_b)
    begin
        if (!frame_rst_b)
        begin
            bit_cnt_q <= 6'h00;
            shift_q <= 32'h0000_0000;
            addr_q <= 8'h00;
            o_read_mode <= 1'b0;
            out_sh_q <= 24'h00_0000;
        end
        else
        begin
            if (bit_cnt_q != FRAME_BITS)
            begin
                bit_cnt_q <= bit_cnt_q + 6'h01;
                shift_q <= shift_next;
            end
            if (addr_done)
            begin
                addr_q <= addr_now;
                o_read_mode <= (addr_now == ADDR_READ);
                out_sh_q <= DATA_BITS'(status_s_q);
            end
            else if (o_read_mode)
                out_sh_q <= {1'b0, out_sh_q[DATA_BITS-1:1]};
        end
    end

    // ----------------------------------------
    // Received words, held across frames
    // ----------------------------------------
    always_ff @(posedge i_serial_clock or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_word_a <= 24'h00_0000;
            o_word_b <= 24'h00_0000;
            o_toggle_a <= 1'b0;
            o_toggle_b <= 1'b0;
            status_m_q <= '0;
            status_s_q <= '0;
        end
        else
        begin
            status_m_q <= i_status;
            status_s_q <= status_m_q;
            // Word counted after 24 data bits
            if (word_done && addr_q == ADDR_CTRL_A)
            begin
                o_word_a <= shift_next[31:8];
                o_toggle_a <= ~o_toggle_a;
            end
            if (word_done && addr_q == ADDR_CTRL_B)
            begin
                o_word_b <= shift_next[31:8];
                o_toggle_b <= ~o_toggle_b;
            end
        end
    end
endmodule

// ===== rtl/pll_synth_core.sv
// Synthesizer digital core: dividers, phase comparator, serial port, register bus
`timescale 1ns/1ps
module pll_synth_core
    import pll_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_serial_clock,
    input wire logic i_serial_enable,
    input wire logic i_serial_data_in,
    output logic o_serial_data_out,
    output logic o_serial_data_out_oe,
    input wire logic i_high_band_osc_in,
    input wire logic i_low_band_osc_in,
    input wire logic i_crystal_input,
    output logic o_phase_output,
    output logic o_phase_output_oe,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [3:0] i_s_axi_awaddr,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    output logic [1:0] o_s_axi_bresp,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    input wire logic [3:0] i_s_axi_araddr,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp
);
    // ----------------------------------------
    // Serial port and crossings
    // ----------------------------------------
    logic [DATA_BITS-1:0] word_a;
    logic [DATA_BITS-1:0] word_b;
    logic tog_a;
    logic tog_b;
    logic read_mode;
    logic out_bit;
    status_t status;
    logic [7:0] meta_q;
    logic [7:0] sync_q;
    logic [7:0] prev_q;
    logic seen_a_q;
    logic seen_b_q;
    ctrl_a_t ctrl_a_q;
    ctrl_b_t ctrl_b_q;
    pll_serial_port u_port (
        .i_serial_clock(i_serial_clock),
        .i_rst_b(i_rst_b),
        .i_enable(i_serial_enable),
        .i_serial_data_in(i_serial_data_in),
        .i_status(status),
        .o_word_a(word_a),
        .o_word_b(word_b),
        .o_toggle_a(tog_a),
        .o_toggle_b(tog_b),
        .o_read_mode(read_mode),
        .o_out_bit(out_bit)
    );
    wire [7:0] async_in = {out_bit, read_mode, tog_b, tog_a, i_crystal_input,
        i_low_band_osc_in, i_high_band_osc_in, i_serial_enable};
    wire ce_s = sync_q[0];
    wire hi_rise = sync_q[1] & ~prev_q[1];
    wire lo_rise = sync_q[2] & ~prev_q[2];
    wire xtal_rise = sync_q[3] & ~prev_q[3];
    wire tog_a_s = sync_q[4];
    wire tog_b_s = sync_q[5];
    wire read_s = sync_q[6];
    wire out_bit_s = sync_q[7];
    // Words are static once enable is low, so a plain copy is safe
    wire apply_a = !ce_s && (tog_a_s != seen_a_q);
    wire apply_b = !ce_s && (tog_b_s != seen_b_q);
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta_q <= 8'h00;
            sync_q <= 8'h00;
            prev_q <= 8'h00;
            seen_a_q <= 1'b0;
            seen_b_q <= 1'b0;
            ctrl_a_q <= '0;
            ctrl_b_q <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
            seen_a_q <= seen_a_q ^ apply_a;
            seen_b_q <= seen_b_q ^ apply_b;
            if (apply_a)
                ctrl_a_q <= ctrl_a_t'(word_a);
            if (apply_b)
                ctrl_b_q <= ctrl_b_t'(word_b);
        end
    end
    // ----------------------------------------
    // Programmable and reference dividers
    // ----------------------------------------
    logic pre_q;
    logic [15:0] div_cnt_q;
    logic div_pulse_q;
    wire inhibit = (ctrl_a_q.ref_sel == REF_SEL_INHIBIT) ||
        (ctrl_a_q.ref_sel == REF_SEL_INHIBIT_STOP);
    wire hi_sel = ctrl_a_q.input_select_bit;
    wire swallow = hi_sel | ctrl_a_q.swallow_mode_bit;
    // High band counts every second edge after the prescaler
    wire div_evt = hi_sel ? (hi_rise & pre_q) : lo_rise;
    wire [15:0] n_sel = swallow ? ctrl_a_q.divisor :
        {4'h0, ctrl_a_q.divisor[15:4]};
    wire div_expire = div_evt && (div_cnt_q <= 16'h0001);
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pre_q <= 1'b0;
            div_cnt_q <= 16'h0000;
            div_pulse_q <= 1'b0;
        end
        else if (inhibit)
        begin
            pre_q <= 1'b0;
            div_cnt_q <= n_sel;
            div_pulse_q <= 1'b0;
        end
        else
        begin
            if (hi_rise)
                pre_q <= ~pre_q;
            div_pulse_q <= div_expire;
            if (div_expire)
                div_cnt_q <= n_sel;
            else if (div_evt)
                div_cnt_q <= div_cnt_q - 16'h0001;
        end
    end
    logic [6:0] ref_div;
    logic [6:0] ref_cnt_q;
    logic ref_pulse_q;
    wire ref_expire = xtal_rise && (ref_cnt_q <= 7'h01);
    always_comb
    begin
        case (ctrl_a_q.ref_sel)
            4'h0, 4'h1, 4'h2, 4'h3: ref_div = REF_DIV_25K;
            4'h4: ref_div = REF_DIV_12K5;
            4'h5: ref_div = REF_DIV_6K25;
            4'h6, 4'h7: ref_div = REF_DIV_3K125;
            4'h8, 4'h9: ref_div = REF_DIV_5K;
            4'ha: ref_div = REF_DIV_1K;
            4'hb: ref_div = REF_DIV_3K;
            4'hc, 4'hd: ref_div = REF_DIV_15K;
            default: ref_div = REF_DIV_25K;
        endcase
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ref_cnt_q <= 7'h00;
            ref_pulse_q <= 1'b0;
        end
        else if (inhibit)
        begin
            ref_cnt_q <= ref_div;
            ref_pulse_q <= 1'b0;
        end
        else
        begin
            ref_pulse_q <= ref_expire;
            if (ref_expire)
                ref_cnt_q <= ref_div;
            else if (xtal_rise)
                ref_cnt_q <= ref_cnt_q - 7'h01;
        end
    end
    // ----------------------------------------
    // Phase comparator, unlock, deadlock and pins
    // ----------------------------------------
    logic up_q;
    logic dn_q;
    logic [15:0] err_cnt_q;
    logic unlock_q;
    logic [15:0] unlock_limit_q;
    wire pending = up_q ^ dn_q;
    wire deadlock = err_cnt_q >= DEADLOCK_CYC;
    wire up_set = up_q | div_pulse_q;
    wire dn_set = dn_q | ref_pulse_q;
    wire dz_ok = !ctrl_b_q.dead_zone || (err_cnt_q >= DEAD_ZONE_CYC);
    assign status = '{unlock: unlock_q, inhibit: inhibit, phase_up: up_q, phase_dn: dn_q};
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
            err_cnt_q <= 16'h0000;
            unlock_q <= 1'b0;
        end
        else
        begin
            // Both flags set means a comparison finished
            up_q <= up_set & ~dn_set & ~deadlock & ~inhibit;
            dn_q <= dn_set & ~up_set & ~deadlock & ~inhibit;
            err_cnt_q <= (pending && !deadlock) ? err_cnt_q + 16'h0001 : 16'h0000;
            if (err_cnt_q >= unlock_limit_q)
                unlock_q <= 1'b1;
            else if (ref_pulse_q && !pending)
                unlock_q <= 1'b0;
        end
    end
    wire pd_drive = pending && dz_ok && !inhibit;
    wire do_oe_d = read_s ? ~out_bit_s :
        (!ce_s && ctrl_b_q.out_ctrl == OUTC_UNLOCK && unlock_q);
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_phase_output <= 1'b0;
            o_phase_output_oe <= 1'b0;
            o_serial_data_out <= 1'b0;
            o_serial_data_out_oe <= 1'b0;
        end
        else
        begin
            o_phase_output <= up_q;
            o_phase_output_oe <= pd_drive;
            o_serial_data_out <= 1'b0;
            o_serial_data_out_oe <= do_oe_d;
        end
    end
    // ----------------------------------------
    // Register bus slave
    // ----------------------------------------
    logic aw_full_q;
    logic w_full_q;
    logic [3:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    wire aw_take = i_s_axi_awvalid && o_s_axi_awready;
    wire w_take = i_s_axi_wvalid && o_s_axi_wready;
    wire ar_take = i_s_axi_arvalid && o_s_axi_arready;
    wire do_write = aw_full_q && w_full_q && !o_s_axi_bvalid;
    wire wr_limit = (aw_addr_q == OFS_UNLOCK_LIMIT);
    wire rd_hit = (i_s_axi_araddr == OFS_STATUS) || (i_s_axi_araddr == OFS_WORD_A) ||
        (i_s_axi_araddr == OFS_WORD_B) || (i_s_axi_araddr == OFS_UNLOCK_LIMIT);
    wire [31:0] rd_data =
        (i_s_axi_araddr == OFS_STATUS) ? 32'(status) :
        (i_s_axi_araddr == OFS_WORD_A) ? 32'(ctrl_a_q) :
        (i_s_axi_araddr == OFS_WORD_B) ? 32'(ctrl_b_q) :
        (i_s_axi_araddr == OFS_UNLOCK_LIMIT) ? 32'(unlock_limit_q) : 32'h0000_0000;
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready <= 1'b0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= RESP_OKAY;
            unlock_limit_q <= UNLOCK_LIMIT_RST;
        end
        else
        begin
            o_s_axi_awready <= i_s_axi_awvalid && !o_s_axi_awready && !aw_full_q;
            o_s_axi_wready <= i_s_axi_wvalid && !o_s_axi_wready && !w_full_q;
            if (aw_take)
            begin
                aw_full_q <= 1'b1;
                aw_addr_q <= i_s_axi_awaddr;
            end
            if (w_take)
            begin
                w_full_q <= 1'b1;
                w_data_q <= i_s_axi_wdata;
                w_strb_q <= i_s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp <= wr_limit ? RESP_OKAY : RESP_SLVERR;
                if (wr_limit && w_strb_q[0])
                    unlock_limit_q[7:0] <= w_data_q[7:0];
                if (wr_limit && w_strb_q[1])
                    unlock_limit_q[15:8] <= w_data_q[15:8];
            end
            else if (i_s_axi_bready)
                o_s_axi_bvalid <= 1'b0;
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h0000_0000;
            o_s_axi_rresp <= RESP_OKAY;
        end
        else
        begin
            o_s_axi_arready <= i_s_axi_arvalid && !o_s_axi_arready && !o_s_axi_rvalid;
            if (ar_take)
            begin
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rdata <= rd_data;
                o_s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (i_s_axi_rready)
                o_s_axi_rvalid <= 1'b0;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);
    AST_HIGH_BAND_ROUTE: assert property (
        (hi_sel && lo_rise && !hi_rise) |-> !div_evt)
        else $error("low band edge counted while high band selected");
    AST_PRESCALE_SKIP: assert property (
        (hi_sel && hi_rise && !pre_q && !inhibit) |=> pre_q && $stable(div_cnt_q))
        else $error("prescaler did not halve the high band edges");
    AST_LOW_BAND_ROUTE: assert property (
        (!hi_sel && lo_rise && !inhibit && div_cnt_q > 16'h0001)
        |=> div_cnt_q == $past(div_cnt_q) - 16'h0001)
        else $error("low band edge not counted");
    AST_SWALLOW_FULL: assert property (
        (!hi_sel && ctrl_a_q.swallow_mode_bit) |-> n_sel == ctrl_a_q.divisor)
        else $error("swallow divisor not used as set");
    AST_DIRECT_RELOAD: assert property (
        (!swallow && div_expire && !inhibit) |=> div_pulse_q &&
        div_cnt_q == {4'h0, $past(ctrl_a_q.divisor[15:4])})
        else $error("direct divider reload wrong");
    AST_REF_RELOAD: assert property (
        (ref_expire && !inhibit) |=> ref_pulse_q && ref_cnt_q == $past(ref_div))
        else $error("reference divider reload wrong");
    AST_DO_OPEN_INPUT: assert property (
        (ce_s && !read_s) ##1 (ce_s && !read_s) |=> !o_serial_data_out_oe)
        else $error("data out driven during input");
    AST_UNLOCK_FLAG: assert property (
        (err_cnt_q >= unlock_limit_q) |=> unlock_q)
        else $error("unlock not flagged");
    AST_PHASE_FLOAT: assert property (
        (!up_q && !dn_q) |=> !o_phase_output_oe)
        else $error("phase output driven while matched");
    AST_PHASE_HIGH: assert property (
        (up_q && !dn_q && dz_ok && !inhibit) |=> o_phase_output && o_phase_output_oe)
        else $error("phase output not high when fast");
    AST_APPLY_AFTER_END: assert property (
        !$stable(ctrl_a_q) |-> !$past(ce_s))
        else $error("control word applied during transfer");
    AST_BVALID_HOLD: assert property (
        (o_s_axi_bvalid && !i_s_axi_bready) |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("write response dropped before ready");
endmodule

// ===== sim/pll_ctrl_model.sv
// Serial controller model for the three-wire port
`timescale 1ns/1ps
module pll_ctrl_model (
    input wire logic i_data_out_oe,
    output logic o_serial_clock,
    output logic o_enable,
    output logic o_data_in
);
    initial
    begin
        o_serial_clock = 1'b0;
        o_enable = 1'b0;
        o_data_in = 1'b1;
    end
    // ----------------------------------------
    // One frame, lsb first; clock idle outside
    // ----------------------------------------
    task automatic xfer(input logic [31:0] bits, input int nbits, input int lo_ns,
        output logic [23:0] rd);
        rd = '0;
        o_enable = 1'b1;
        for (int i = 0; i < nbits; i++)
        begin
            o_data_in = bits[i];
            #(lo_ns);
            if (i > 7)
                rd[i-8] = ~i_data_out_oe;
            o_serial_clock = 1'b1;
            #15;
            o_serial_clock = 1'b0;
        end
        #15;
        o_enable = 1'b0;
        o_data_in = ~o_data_in;
    endtask
endmodule

// ===== sim/pll_synth_core_tb_top.sv
// Bench for the synthesizer digital core
`timescale 1ns/1ps
module pll_synth_core_tb_top;
    import pll_pkg::*;
    logic i_sys_clk, i_rst_b, sclk, sen, sdi, sdo, ph, do_oe, ph_oe, hb, lb, xt;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, got;
    logic [1:0] bresp, rresp, rr;
    logic [23:0] rw;
    ctrl_a_t wa;
    int miscompares, cmp_count;
    pll_synth_core dut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_serial_clock(sclk),
        .i_serial_enable(sen), .i_serial_data_in(sdi), .o_serial_data_out(sdo),
        .o_serial_data_out_oe(do_oe), .i_high_band_osc_in(hb), .i_low_band_osc_in(lb),
        .i_crystal_input(xt), .o_phase_output(ph), .o_phase_output_oe(ph_oe),
        .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
        .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
        .i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
        .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
        .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
        .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp));
    pll_ctrl_model ctl (.i_data_out_oe(do_oe), .o_serial_clock(sclk), .o_enable(sen),
        .o_data_in(sdi));
    // ----------------------------------------
    // Clocks and helpers
    // ----------------------------------------
    initial
    begin
        i_sys_clk = 1'b0;
        hb = 1'b0;
        lb = 1'b0;
        xt = 1'b0;
        fork
            forever #5 i_sys_clk = ~i_sys_clk;
            forever #40 hb = ~hb;
            forever #60 lb = ~lb;
            forever #500 xt = ~xt;
        join
    end
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_sys_clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (int n = 0; n < 50; n++)
        begin
            @(posedge i_sys_clk);
            if (arvalid && arready === 1'b1)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                return;
            end
        end
        miscompares++;
        final_report();
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [1:0] r);
        @(posedge i_sys_clk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        bready <= 1'b1;
        for (int n = 0; n < 50; n++)
        begin
            @(posedge i_sys_clk);
            if (awvalid && awready === 1'b1)
                awvalid <= 1'b0;
            if (wvalid && wready === 1'b1)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
            begin
                r = bresp;
                bready <= 1'b0;
                return;
            end
        end
        miscompares++;
        final_report();
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {i_rst_b, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (6) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        chk({30'h0, do_oe, ph_oe}, 32'h0);
        axi_rd(OFS_WORD_A, got, rr);
        chk(got, 32'h0);
        axi_rd(OFS_WORD_B, got, rr);
        chk(got, 32'h0);
        axi_rd(OFS_UNLOCK_LIMIT, got, rr);
        chk(got, 32'(UNLOCK_LIMIT_RST));
        axi_wr(OFS_UNLOCK_LIMIT, 32'hffff_1234, 4'hf, rr);
        chk({30'h0, rr}, {30'h0, RESP_OKAY});
        axi_rd(OFS_UNLOCK_LIMIT, got, rr);
        chk(got, 32'h1234);
        axi_wr(OFS_UNLOCK_LIMIT, 32'hffff_56ab, 4'h1, rr);
        axi_rd(OFS_UNLOCK_LIMIT, got, rr);
        chk(got, 32'h12ab);
        axi_wr(OFS_STATUS, 32'h0000_000f, 4'hf, rr);
        chk({30'h0, rr}, {30'h0, RESP_SLVERR});
        axi_rd(4'h2, got, rr);
        chk({got[31:2], rr}, {30'h0, RESP_SLVERR});
        for (int k = 0; k < 3; k++)
        begin
            wa = '{2'h0, (k == 2) ? REF_SEL_INHIBIT : 4'(k + 4), k == 1, k == 0,
                16'h1234 + 16'(k)};
            ctl.xfer({wa, ADDR_CTRL_A}, 32, 15, rw);
            repeat (10) @(posedge i_sys_clk);
            axi_rd(OFS_WORD_A, got, rr);
            chk(got, {8'h0, wa});
        end
        ctl.xfer({24'h0, ADDR_CTRL_A}, 20, 15, rw);
        repeat (10) @(posedge i_sys_clk);
        axi_rd(OFS_WORD_A, got, rr);
        chk(got, {8'h0, wa});
        chk({29'h0, sdo, ph, ph_oe}, 32'h0);
        ctl.xfer({21'h0, OUTC_UNLOCK, ADDR_CTRL_B}, 32, 15, rw);
        repeat (10) @(posedge i_sys_clk);
        axi_rd(OFS_WORD_B, got, rr);
        chk(got, {29'h0, OUTC_UNLOCK});
        axi_rd(OFS_STATUS, got, rr);
        chk(got, 32'h4);
        chk({31'h0, do_oe}, {31'h0, got[3]});
        ctl.xfer({24'h0, ADDR_READ}, 32, 60, rw);
        repeat (10) @(posedge i_sys_clk);
        chk({8'h0, rw}, {28'h0, got[3:0]});
        chk({31'h0, got[2]}, 32'h1);
        final_report();
    end
    initial
    begin
        #900000;
        miscompares++;
        final_report();
    end
endmodule
